// ===== verilog/gits_pkg.sv
/*
 Package for the gated intensifier timing sequencer: register offsets,
 field positions, reset values, timing counts and shared types.
 Assumes a 250 MHz APB clock (4 ns period).
*/
package gits_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  // Exposure window tail after the last pulse set
  localparam int unsigned EXPO_TAIL_NS = 15;
  localparam int unsigned EXPO_TAIL_CYC =
    (EXPO_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Shortest gate and shortest dual-frame spacing the block must reach
  localparam int unsigned MIN_GATE_NS = 5;
  localparam int unsigned MIN_GATE_CYC =
    (MIN_GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_SPACING_US = 2;
  localparam int unsigned MIN_SPACING_CYC =
    MIN_SPACING_US * 1000 / CLK_PERIOD_NS;

  localparam int TW = 24;
  localparam int CW = 16;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REPEAT = 8'h08;
  localparam logic [7:0] REG_WIDTH_START = 8'h0C;
  localparam logic [7:0] REG_WIDTH_END = 8'h10;
  localparam logic [7:0] REG_DELAY_START = 8'h14;
  localparam logic [7:0] REG_DELAY_END = 8'h18;
  localparam logic [7:0] REG_WIDTH_STEP = 8'h1C;
  localparam logic [7:0] REG_DELAY_STEP = 8'h20;
  localparam logic [7:0] REG_AUX_DELAY = 8'h24;
  localparam logic [7:0] REG_AUX_WIDTH = 8'h28;
  localparam logic [7:0] REG_SYNC_HALF = 8'h2C;
  localparam logic [7:0] REG_INT_PERIOD = 8'h30;
  localparam logic [7:0] REG_INTER_DELAY = 8'h34;
  localparam logic [7:0] REG_DONE_COUNT = 8'h38;

  // CTRL field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_EXT_SEL = 1;
  localparam int CTRL_SWEEP = 2;
  localparam int CTRL_DUAL = 3;
  localparam int CTRL_DUAL_TWO = 4;
  localparam int CTRL_EXT_FALL = 5;
  localparam int CTRL_SYNC_EN = 6;
  // STATUS field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_EXPO = 2;
  localparam int STAT_STORED = 3;

  localparam logic [TW-1:0] RST_WIDTH = 24'h000002;
  localparam logic [TW-1:0] RST_DELAY = 24'h000001;
  localparam logic [TW-1:0] RST_AUX_WIDTH = 24'h000001;
  localparam logic [TW-1:0] RST_SYNC_HALF = 24'h000019;
  localparam logic [TW-1:0] RST_INT_PERIOD = 24'h0003E8;
  localparam logic [TW-1:0] RST_INTER_DELAY = 24'h0001F4;
  localparam logic [CW-1:0] RST_REPEAT = 16'h0001;

  typedef struct packed {
    logic intensifier_gate;
    logic gate_open_mark;
    logic gate_close_mark;
    logic auxiliary_pulse_out;
    logic sync_clock_out;
  } gits_pulse_t;

  typedef struct packed {
    logic [TW-1:0] delay;
    logic [TW-1:0] width;
    logic [TW-1:0] aux_delay;
    logic [TW-1:0] aux_width;
  } gits_shape_t;

endpackage : gits_pkg

// ===== verilog/gits_pulse_gen.sv
/*
 One pulse set generator: on start it counts the delay, then holds the
 gate open for the width, with open and close markers and an aux pulse.
 Assumes the same pclk domain as the sequencer and width of at least 1.
*/
`timescale 1ns/1ns
`default_nettype none
module gits_pulse_gen (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic start, // One-cycle start of a pulse set
  input wire gits_pkg::gits_shape_t shape, // Delay, width, aux timing
  output gits_pkg::gits_pulse_t pulse, // Registered pulse outputs
  output logic done // One-cycle pulse set complete
);

  logic [gits_pkg::TW:0] cnt;
  logic running;
  logic [gits_pkg::TW:0] open_at;
  logic [gits_pkg::TW:0] close_at;
  logic [gits_pkg::TW:0] aux_on;
  logic [gits_pkg::TW:0] aux_off;
  logic [gits_pkg::TW:0] last_at;

  assign open_at = {1'b0, shape.delay};
  assign close_at = {1'b0, shape.delay} + {1'b0, shape.width};
  assign aux_on = {1'b0, shape.aux_delay};
  assign aux_off = {1'b0, shape.aux_delay} + {1'b0, shape.aux_width};
  assign last_at = (close_at > aux_off) ? close_at : aux_off;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !running) begin
        running <= 1'b1;
        cnt <= '0;
      end else if (running) begin
        cnt <= cnt + 1'b1;
        if (cnt == last_at) begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Gate spans open marker to close marker of the same set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse.intensifier_gate <= 1'b0;
      pulse.gate_open_mark <= 1'b0;
      pulse.gate_close_mark <= 1'b0;
      pulse.auxiliary_pulse_out <= 1'b0;
      pulse.sync_clock_out <= 1'b0;
    end else begin
      pulse.gate_open_mark <= running && (cnt == open_at);
      pulse.gate_close_mark <= running && (cnt == close_at);
      pulse.intensifier_gate <= running && (cnt >= open_at)
        && (cnt < close_at);
      pulse.auxiliary_pulse_out <= running && (cnt >= aux_on)
        && (cnt < aux_off);
      // Sync output is made by the sequencer
      pulse.sync_clock_out <= 1'b0;
    end
  end

endmodule : gits_pulse_gen
`default_nettype wire

// ===== verilog/gits_sequencer.sv
/*
 Gated intensifier timing sequencer with APB register slave.
 Waits for triggers after a start handover, runs repeated pulse sets,
 drives the exposure window and hands control back when done.
 Assumes the trigger pin is asynchronous; APB runs on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module gits_sequencer (
  input wire logic pclk, // APB and sequencer clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic trigger_in, // External trigger pin, async
  input wire logic readout_done, // First image read out, same domain
  output logic intensifier_gate, // Photocathode gate
  output logic gate_open_mark, // Gate-open marker
  output logic gate_close_mark, // Gate-close marker
  output logic auxiliary_pulse_out, // Auxiliary pulse
  output logic sync_clock_out, // Sync output
  output logic exposure_window, // High across the pulse sets
  output logic image_store, // Move first image under mask
  output logic control_returned // Pulse: control back to camera
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_WAIT = 6'b000010,
    ST_RUN = 6'b000100,
    ST_GAP = 6'b001000,
    ST_TAIL = 6'b010000,
    ST_DONE = 6'b100000
  } gits_state_t;

  gits_state_t state;
  logic [31:0] ctrl;
  logic [gits_pkg::CW-1:0] repeat_num;
  logic [gits_pkg::TW-1:0] w_start, w_end, d_start, d_end;
  logic [gits_pkg::TW-1:0] w_step, d_step;
  logic [gits_pkg::TW-1:0] aux_delay, aux_width, sync_half;
  logic [gits_pkg::TW-1:0] int_period, inter_delay;
  logic [gits_pkg::TW-1:0] cur_width, cur_delay;
  logic [gits_pkg::CW-1:0] done_count;
  logic [gits_pkg::TW-1:0] gap_cnt, int_cnt, sync_cnt;
  logic [3:0] tail_cnt;
  logic done_flag, stored, frame_idx;
  logic trig_s1, trig_s2, trig_s3;
  logic ext_edge, int_tick, trig_fire, set_start, set_done;
  logic wr_en, rd_en, hit;
  gits_pkg::gits_shape_t shape;
  gits_pkg::gits_pulse_t pulse;
  logic [31:0] next_rdata;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Register writes; start bit self clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      repeat_num <= gits_pkg::RST_REPEAT;
      w_start <= gits_pkg::RST_WIDTH;
      w_end <= gits_pkg::RST_WIDTH;
      d_start <= gits_pkg::RST_DELAY;
      d_end <= gits_pkg::RST_DELAY;
      w_step <= '0;
      d_step <= '0;
      aux_delay <= '0;
      aux_width <= gits_pkg::RST_AUX_WIDTH;
      sync_half <= gits_pkg::RST_SYNC_HALF;
      int_period <= gits_pkg::RST_INT_PERIOD;
      inter_delay <= gits_pkg::RST_INTER_DELAY;
    end else begin
      ctrl[gits_pkg::CTRL_START] <= 1'b0;
      if (wr_en) begin
        case (paddr)
          gits_pkg::REG_CTRL: ctrl <= pwdata;
          gits_pkg::REG_REPEAT: repeat_num <= pwdata[gits_pkg::CW-1:0];
          gits_pkg::REG_WIDTH_START: w_start <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_WIDTH_END: w_end <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_DELAY_START: d_start <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_DELAY_END: d_end <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_WIDTH_STEP: w_step <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_DELAY_STEP: d_step <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_AUX_DELAY: aux_delay <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_AUX_WIDTH: aux_width <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_SYNC_HALF: sync_half <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_INT_PERIOD: int_period <= pwdata[gits_pkg::TW-1:0];
          gits_pkg::REG_INTER_DELAY: inter_delay <= pwdata[gits_pkg::TW-1:0];
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    hit = 1'b1;
    next_rdata = '0;
    case (paddr)
      gits_pkg::REG_CTRL: next_rdata = ctrl;
      gits_pkg::REG_STATUS: begin
        next_rdata[gits_pkg::STAT_BUSY] = (state != ST_IDLE);
        next_rdata[gits_pkg::STAT_DONE] = done_flag;
        next_rdata[gits_pkg::STAT_EXPO] = exposure_window;
        next_rdata[gits_pkg::STAT_STORED] = stored;
      end
      gits_pkg::REG_REPEAT: next_rdata[gits_pkg::CW-1:0] = repeat_num;
      gits_pkg::REG_WIDTH_START: next_rdata[gits_pkg::TW-1:0] = w_start;
      gits_pkg::REG_WIDTH_END: next_rdata[gits_pkg::TW-1:0] = w_end;
      gits_pkg::REG_DELAY_START: next_rdata[gits_pkg::TW-1:0] = d_start;
      gits_pkg::REG_DELAY_END: next_rdata[gits_pkg::TW-1:0] = d_end;
      gits_pkg::REG_WIDTH_STEP: next_rdata[gits_pkg::TW-1:0] = w_step;
      gits_pkg::REG_DELAY_STEP: next_rdata[gits_pkg::TW-1:0] = d_step;
      gits_pkg::REG_AUX_DELAY: next_rdata[gits_pkg::TW-1:0] = aux_delay;
      gits_pkg::REG_AUX_WIDTH: next_rdata[gits_pkg::TW-1:0] = aux_width;
      gits_pkg::REG_SYNC_HALF: next_rdata[gits_pkg::TW-1:0] = sync_half;
      gits_pkg::REG_INT_PERIOD: next_rdata[gits_pkg::TW-1:0] = int_period;
      gits_pkg::REG_INTER_DELAY: next_rdata[gits_pkg::TW-1:0] = inter_delay;
      gits_pkg::REG_DONE_COUNT: next_rdata[gits_pkg::CW-1:0] = done_count;
      default: hit = 1'b0;
    endcase
  end

  // Zero wait state slave; data latched in setup so it is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en) begin
        prdata <= next_rdata;
      end
    end
  end

  // Trigger pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trigger_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  assign ext_edge = ctrl[gits_pkg::CTRL_EXT_FALL]
    ? (trig_s3 && !trig_s2) : (!trig_s3 && trig_s2);

  // Internal trigger generator, free running while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt <= '0;
      int_tick <= 1'b0;
    end else begin
      int_tick <= 1'b0;
      if (state == ST_IDLE || int_cnt >= int_period) begin
        int_cnt <= '0;
        int_tick <= (state != ST_IDLE);
      end else begin
        int_cnt <= int_cnt + 1'b1;
      end
    end
  end

  // Source selection; software keeps one source per sequence
  assign trig_fire = ctrl[gits_pkg::CTRL_EXT_SEL] ? ext_edge
    : int_tick;

  // Second dual-frame shot in one-trigger mode runs off the gap timer
  assign set_start = (state == ST_WAIT && trig_fire)
    || (state == ST_GAP && gap_cnt == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      done_count <= '0;
      frame_idx <= 1'b0;
      gap_cnt <= '0;
      tail_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ctrl[gits_pkg::CTRL_START] && repeat_num != '0) begin
            state <= ST_WAIT;
            done_count <= '0;
            frame_idx <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (set_start) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (set_done) begin
            done_count <= done_count + 1'b1;
            frame_idx <= ~frame_idx;
            if (done_count + 1'b1 == repeat_num) begin
              state <= ST_TAIL;
              tail_cnt <= 4'(gits_pkg::EXPO_TAIL_CYC);
            end else if (ctrl[gits_pkg::CTRL_DUAL] && !frame_idx
                && !ctrl[gits_pkg::CTRL_DUAL_TWO]) begin
              state <= ST_GAP;
              gap_cnt <= inter_delay;
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        ST_GAP: begin
          gap_cnt <= gap_cnt - 1'b1;
          if (set_start) begin
            state <= ST_RUN;
          end
        end
        ST_TAIL: begin
          tail_cnt <= tail_cnt - 1'b1;
          if (tail_cnt == 4'h1) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Swept or static gate parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_width <= gits_pkg::RST_WIDTH;
      cur_delay <= gits_pkg::RST_DELAY;
    end else if (state == ST_IDLE) begin
      cur_width <= w_start;
      cur_delay <= d_start;
    end else if (set_done && ctrl[gits_pkg::CTRL_SWEEP]) begin
      cur_width <= (w_end >= w_start)
        ? ((cur_width + w_step > w_end) ? w_end : cur_width + w_step)
        : ((cur_width < w_end + w_step) ? w_end
          : cur_width - w_step);
      cur_delay <= (d_end >= d_start)
        ? ((cur_delay + d_step > d_end) ? d_end : cur_delay + d_step)
        : ((cur_delay < d_end + d_step) ? d_end
          : cur_delay - d_step);
    end
  end

  // Static mode keeps start values for every pulse
  assign shape.width = cur_width;
  assign shape.delay = cur_delay;
  assign shape.aux_delay = aux_delay;
  assign shape.aux_width = aux_width;

  gits_pulse_gen u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .start(set_start),
    .shape(shape),
    .pulse(pulse),
    .done(set_done)
  );

  // Sync clock runs while a sequence is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt <= '0;
      sync_clock_out <= 1'b0;
    end else if (!ctrl[gits_pkg::CTRL_SYNC_EN] || state == ST_IDLE) begin
      sync_cnt <= '0;
      sync_clock_out <= 1'b0;
    end else if (sync_cnt >= sync_half) begin
      sync_cnt <= '0;
      sync_clock_out <= ~sync_clock_out;
    end else begin
      sync_cnt <= sync_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intensifier_gate <= 1'b0;
      gate_open_mark <= 1'b0;
      gate_close_mark <= 1'b0;
      auxiliary_pulse_out <= 1'b0;
      exposure_window <= 1'b0;
      control_returned <= 1'b0;
    end else begin
      intensifier_gate <= pulse.intensifier_gate;
      gate_open_mark <= pulse.gate_open_mark;
      gate_close_mark <= pulse.gate_close_mark;
      auxiliary_pulse_out <= pulse.auxiliary_pulse_out;
      exposure_window <= (state == ST_RUN) || (state == ST_GAP)
        || (state == ST_TAIL)
        || (state == ST_WAIT && done_count != '0);
      control_returned <= (state == ST_DONE);
    end
  end

  // First dual-frame image parked under mask until readout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored <= 1'b0;
      image_store <= 1'b0;
    end else begin
      image_store <= ctrl[gits_pkg::CTRL_DUAL] && set_done && !frame_idx;
      if (ctrl[gits_pkg::CTRL_DUAL] && set_done && !frame_idx) begin
        stored <= 1'b1;
      end else if (readout_done) begin
        stored <= 1'b0;
      end
    end
  end

  // Set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
    end else if (state == ST_DONE) begin
      done_flag <= 1'b1;
    end else if (state == ST_IDLE && ctrl[gits_pkg::CTRL_START]) begin
      done_flag <= 1'b0;
    end
  end

endmodule : gits_sequencer
`default_nettype wire

// ===== test/gits_props.sv
/*
 Checker for the sequencer's port behaviour, bound to gits_sequencer.
 Assumes one pclk domain and async active-low presetn.
*/
`timescale 1ns/1ns
`default_nettype none
module gits_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pready, // APB ready
  input wire logic intensifier_gate, // Gate
  input wire logic gate_open_mark, // Open marker
  input wire logic gate_close_mark, // Close marker
  input wire logic exposure_window, // Window
  input wire logic image_store, // Store pulse
  input wire logic control_returned // Return pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  idle_reset_a: assert property ($rose(presetn) |->
    !exposure_window && !intensifier_gate) else $error("not idle");
  gate_window_a: assert property (intensifier_gate |->
    exposure_window) else $error("gate outside window");
  open_window_a: assert property (gate_open_mark |->
    exposure_window) else $error("marker outside window");
  open_gate_a: assert property ($rose(intensifier_gate) |->
    ##[0:4] gate_open_mark) else $error("no open marker");
  close_gate_a: assert property (gate_close_mark |->
    ##[0:2] !intensifier_gate) else $error("gate open past close");
  tail_gap_a: assert property ($fell(exposure_window) |->
    !$past(intensifier_gate) && !$past(intensifier_gate, 3))
    else $error("window tail too short");
  return_a: assert property ($fell(exposure_window) &&
    $past(presetn) |-> ##[0:2] control_returned) else $error("no return");
  return_pulse_a: assert property (control_returned |=>
    !control_returned && !exposure_window) else $error("bad return");
  store_pulse_a: assert property (image_store |=>
    !image_store) else $error("store not a pulse");
  apb_ready_a: assert property (psel && !penable |=>
    pready) else $error("ready late");
endmodule : gits_props
bind gits_sequencer gits_props gits_props_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .intensifier_gate(intensifier_gate), .gate_open_mark(gate_open_mark),
  .gate_close_mark(gate_close_mark), .exposure_window(exposure_window),
  .image_store(image_store), .control_returned(control_returned));
`default_nettype wire

// ===== test/gits_trig_src.sv
/*
 External trigger source model: a fire request gives one wide pulse.
 Assumes the bench asks for one fire per wanted trigger pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module gits_trig_src (
  input wire logic pclk, // Clock
  input wire logic fire, // One-cycle request
  output logic trigger_in // Pin level
);
  logic [3:0] n = 4'h0;
  // Wide pulse so the sync flops cannot miss it
  always @(posedge pclk) begin
    if (fire) n <= 4'hF;
    else if (n != 4'h0) n <= n - 4'h1;
    trigger_in <= (n != 4'h0);
  end
endmodule : gits_trig_src
`default_nettype wire

// ===== test/gits_sequencer_test.sv
/*
 Testbench: APB tasks, trigger model, port counters, sequence checks.
 Assumes the sequencer and checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module gits_sequencer_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, se, trig, fire = 0, rdone = 0;
  logic gate, om, cm, aux, sy, win, st, ret, sy_q = 0;
  int err_count = 0, comparisons = 0;
  int opens, closes, gcyc, acyc, syncs, stores, rets;
  int us_cyc = 0, us_now = 0, t_start = 0, t_end = 0;
  localparam int US_CYC = 1000 / gits_pkg::CLK_PERIOD_NS;
  localparam int INIT_US = 75;
  // Phosphor decay stand-in, plain default
  localparam int DECAY_CYC = 500;
  gits_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_in(trig), .readout_done(rdone), .intensifier_gate(gate),
    .gate_open_mark(om), .gate_close_mark(cm), .auxiliary_pulse_out(aux),
    .sync_clock_out(sy), .exposure_window(win), .image_store(st),
    .control_returned(ret));
  gits_trig_src src_u (.pclk(pclk), .fire(fire), .trigger_in(trig));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    opens += (om === 1'b1);
    closes += (cm === 1'b1);
    gcyc += (gate === 1'b1);
    acyc += (aux === 1'b1);
    syncs += (sy === 1'b1 && sy_q === 1'b0);
    stores += (st === 1'b1);
    rets += (ret === 1'b1);
    sy_q <= sy;
    rdone <= (st === 1'b1);
    // Camera side stamps, counted in whole microseconds
    us_cyc <= (us_cyc == US_CYC - 1) ? 0 : us_cyc + 1;
    if (us_cyc == US_CYC - 1) us_now <= us_now + 1;
    if (ret === 1'b1) t_end <= us_now;
  end
  task test_done;
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task clr;
    {opens, closes, gcyc, acyc, syncs, stores, rets} = '0;
  endtask : clr
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task shot;
    fire <= 1;
    @(posedge pclk);
    fire <= 0;
    cyc(150);
  endtask : shot
  task go(input logic [31:0] ctrl, input logic [15:0] rep);
    clr();
    xfer(1, gits_pkg::REG_REPEAT, {16'h0, rep});
    xfer(1, gits_pkg::REG_CTRL, ctrl);
    t_start = us_now;
  endtask : go
  task wret;
    int n;
    for (n = 0; n < 50000 && rets == 0; n++) @(posedge pclk);
    chk(rets, 1);
  endtask : wret
  initial begin
    cyc(6);
    presetn <= 1;
    xfer(0, gits_pkg::REG_REPEAT, 0);
    chk(r, {16'h0, gits_pkg::RST_REPEAT});
    xfer(0, gits_pkg::REG_INT_PERIOD, 0);
    chk(r, {8'h0, gits_pkg::RST_INT_PERIOD});
    xfer(0, 8'h3C, 0);
    chk({r, se}, {32'h0, 1'b1});
    xfer(1, gits_pkg::REG_WIDTH_START, 32'h4);
    xfer(1, gits_pkg::REG_WIDTH_END, 32'h4);
    xfer(1, gits_pkg::REG_DELAY_START, 32'h3);
    xfer(1, gits_pkg::REG_DELAY_END, 32'h3);
    xfer(1, gits_pkg::REG_AUX_WIDTH, 32'h2);
    xfer(1, gits_pkg::REG_SYNC_HALF, 32'h2);
    xfer(1, gits_pkg::REG_INT_PERIOD, 32'h63);
    xfer(1, gits_pkg::REG_INTER_DELAY, 32'h1E);
    // Internal trigger, static gate, three sets
    go(32'h41, 16'h3);
    wret();
    chk({opens, closes}, {32'd3, 32'd3});
    chk(gcyc, 12);
    chk(acyc, 6);
    chk(syncs > 0, 1);
    xfer(0, gits_pkg::REG_DONE_COUNT, 0);
    chk(r, 3);
    // Swept width 2, 4, 6 with delay stepping too
    xfer(1, gits_pkg::REG_WIDTH_START, 32'h2);
    xfer(1, gits_pkg::REG_WIDTH_END, 32'h6);
    xfer(1, gits_pkg::REG_WIDTH_STEP, 32'h2);
    xfer(1, gits_pkg::REG_DELAY_END, 32'h7);
    xfer(1, gits_pkg::REG_DELAY_STEP, 32'h2);
    go(32'h45, 16'h3);
    wret();
    chk(gcyc, 12);
    xfer(1, gits_pkg::REG_WIDTH_START, 32'h4);
    xfer(1, gits_pkg::REG_WIDTH_END, 32'h4);
    // External source: nothing until the pin moves
    go(32'h03, 16'h2);
    cyc(200);
    chk(opens, 0);
    shot();
    chk({opens, rets}, {32'd1, 32'd0});
    chk(win, 1);
    shot();
    wret();
    chk(opens, 2);
    // Dual frame, one trigger; software keeps delay and decay limits
    xfer(1, gits_pkg::REG_DELAY_START, INIT_US * US_CYC);
    xfer(1, gits_pkg::REG_INTER_DELAY, DECAY_CYC);
    go(32'h0B, 16'h2);
    shot();
    wret();
    chk({opens, stores}, {32'd2, 32'd1});
    cyc(1);
    chk(t_end - t_start >= 2 * INIT_US, 1);
    xfer(1, gits_pkg::REG_DELAY_START, 32'h3);
    // Dual frame, a trigger for each shot, falling edge active
    go(32'h3B, 16'h2);
    shot();
    cyc(200);
    chk({opens, rets}, {32'd1, 32'd0});
    shot();
    wret();
    chk(opens, 2);
    // Zero repeat must not start
    go(32'h41, 16'h0);
    xfer(0, gits_pkg::REG_STATUS, 0);
    chk(r & 32'h1, 0);
    test_done();
  end
  initial begin
    #240000;
    err_count++;
    test_done();
  end
endmodule : gits_sequencer_test
`default_nettype wire
